// ---- design/lat_translator.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lat_defs.svh"

module lat_translator
    import lat_pkg::*;
#(
    parameter int HOST_SIZE = `LAT_HOST_SIZE,
    parameter int EMU_SIZE = `LAT_EMU_SIZE
) (
    input wire logic clock_i, // 10 MHz clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic start_i, // Pulse: begin a conversion.
    input wire logic [7:0] hund_i, // Hundreds character.
    input wire logic [7:0] tens_i, // Tens character.
    input wire logic [7:0] units_i, // Units character.
    input wire logic a_field_i, // Address belongs to the first operand.
    input wire logic dec_first_i, // Pulse: step first pair down by one.
    input wire logic dec_second_i, // Pulse: step second pair down by one.
    output logic tbl_req_o, // Table read request, held until ack.
    output logic [7:0] tbl_addr_o, // Table address.
    output logic tbl_aux_o, // High selects the auxiliary table area.
    input wire logic tbl_ack_i, // Table data valid this cycle.
    input wire logic [7:0] tbl_data_i, // Table readout.
    output logic busy_o, // Conversion in progress.
    output logic done_o, // Pulse: address pairs updated.
    output logic invalid_digit_flag_o, // Invalid digit seen.
    output logic wrap_o, // Result beyond top of host storage.
    output logic [3:0] zone_o, // Hundreds and units zone bits.
    output logic [15:0] bias_o, // Storage bias, high byte and low byte.
    output logic [15:0] first_operand_addr_pair_o, // First-operand address.
    output logic [15:0] second_operand_addr_pair_o // Second-operand address.
);

    // ==========================================================
    // Parameter check
    if (EMU_SIZE < 1 || EMU_SIZE > HOST_SIZE || HOST_SIZE > 65536) begin : g_bad
        $error("lat_translator: storage sizes out of range");
    end

    // ==========================================================
    // Helpers
    // Undo the nibble crossing of a round-number entry.
    function automatic logic [7:0] unswap(input logic [7:0] b);
        return {b[3:0], b[7:4]};
    endfunction

    // A readout is bad when its weight 0x10 bit is set.
    function automatic logic bad_bit(input logic [7:0] b);
        return b[`LAT_INVALID_BIT];
    endfunction

    localparam logic [16:0] HOST_TOP = 17'(HOST_SIZE);
    localparam logic [15:0] BIAS = 16'(HOST_SIZE - EMU_SIZE);

    // ==========================================================
    // Reset release
    // Release is synchronised so that all state leaves reset on one edge.
    logic rst_q1_r;
    logic rst_q2_r;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q1_r <= 1'b0;
            rst_q2_r <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_q2_r <= rst_q1_r;
        end
    end
    wire logic rst_n = rst_q2_r;

    // ==========================================================
    // Sequencer state
    lat_state_t st_r, st_nxt;
    logic [3:0] tens_r, tens_nxt;
    logic [3:0] units_r, units_nxt;
    logic afield_r, afield_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic req_r, req_nxt;
    logic [7:0] taddr_r, taddr_nxt;
    logic aux_r, aux_nxt;
    logic inv_r, inv_nxt;
    logic done_r, done_nxt;
    logic wrap_r, wrap_nxt;
    logic [3:0] zone_r, zone_nxt;
    logic [15:0] bias_r;
    logic [15:0] first_r, first_nxt;
    logic [15:0] second_r, second_nxt;
    logic [16:0] sum;

    // Next-state logic. Each lookup holds its request until the ack, then
    // raises the next request in the following cycle, so lookups can run
    // back to back with no idle cycle between them.
    always_comb begin
        st_nxt = st_r;
        tens_nxt = tens_r;
        units_nxt = units_r;
        afield_nxt = afield_r;
        acc_nxt = acc_r;
        req_nxt = req_r;
        taddr_nxt = taddr_r;
        aux_nxt = aux_r;
        inv_nxt = inv_r;
        done_nxt = 1'b0;
        wrap_nxt = wrap_r;
        zone_nxt = zone_r;
        first_nxt = first_r;
        second_nxt = second_r;
        sum = {1'b0, acc_r} + {9'h000, tbl_data_i};
        // The pairs count down between conversions.
        if (dec_first_i) begin
            first_nxt = first_r - 16'h0001;
        end
        if (dec_second_i) begin
            second_nxt = second_r - 16'h0001;
        end
        unique case (st_r)
            LAT_IDLE: begin
                if (start_i) begin
                    tens_nxt = tens_i[3:0];
                    units_nxt = units_i[3:0];
                    afield_nxt = a_field_i;
                    // Zones are reported here and kept out of the table address.
                    zone_nxt = {hund_i[5:4], units_i[5:4]};
                    taddr_nxt = {`LAT_HUND_PAGE, hund_i[3:0]};
                    aux_nxt = 1'b0;
                    req_nxt = 1'b1;
                    inv_nxt = 1'b0;
                    wrap_nxt = 1'b0;
                    st_nxt = LAT_HUND_LO;
                end
            end
            LAT_HUND_LO: begin
                if (tbl_ack_i) begin
                    // Only the hundreds value: tens and units count as zero.
                    // The low byte is stored crossed like the tens entries, so it is
                    // restored here. The flag test below looks at the raw readout,
                    // which keeps a biased low byte from posing as a bad digit.
                    acc_nxt = {8'h00, unswap(tbl_data_i)};
                    inv_nxt = inv_r | bad_bit(tbl_data_i);
                    aux_nxt = 1'b1;
                    st_nxt = LAT_HUND_HI;
                end
            end
            LAT_HUND_HI: begin
                if (tbl_ack_i) begin
                    // The bias lives in the table entries themselves.
                    acc_nxt = {tbl_data_i, acc_r[7:0]};
                    aux_nxt = 1'b0;
                    taddr_nxt = {`LAT_TENS_PAGE, tens_r};
                    st_nxt = LAT_TENS;
                end
            end
            LAT_TENS: begin
                if (tbl_ack_i) begin
                    // Tens entries are crossed, so restore them before adding.
                    acc_nxt = 16'(({1'b0, acc_r} + {9'h000, unswap(tbl_data_i)}));
                    inv_nxt = inv_r | bad_bit(tbl_data_i);
                    taddr_nxt = {`LAT_UNITS_PAGE, units_r};
                    st_nxt = LAT_UNITS;
                end
            end
            LAT_UNITS: begin
                if (tbl_ack_i) begin
                    acc_nxt = sum[15:0];
                    inv_nxt = inv_r | bad_bit(tbl_data_i);
                    // Same check the host applies to any storage access.
                    wrap_nxt = sum[16] | (sum >= HOST_TOP);
                    second_nxt = sum[15:0];
                    if (afield_r) begin
                        first_nxt = sum[15:0];
                    end
                    req_nxt = 1'b0;
                    done_nxt = 1'b1;
                    st_nxt = LAT_IDLE;
                end
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LAT_IDLE;
            tens_r <= 4'h0;
            units_r <= 4'h0;
            afield_r <= 1'b0;
            acc_r <= 16'h0000;
            req_r <= 1'b0;
            taddr_r <= 8'h00;
            aux_r <= 1'b0;
            inv_r <= 1'b0;
            done_r <= 1'b0;
            wrap_r <= 1'b0;
            zone_r <= 4'h0;
            bias_r <= 16'h0000;
            first_r <= 16'h0000;
            second_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            tens_r <= tens_nxt;
            units_r <= units_nxt;
            afield_r <= afield_nxt;
            acc_r <= acc_nxt;
            req_r <= req_nxt;
            taddr_r <= taddr_nxt;
            aux_r <= aux_nxt;
            inv_r <= inv_nxt;
            done_r <= done_nxt;
            wrap_r <= wrap_nxt;
            zone_r <= zone_nxt;
            bias_r <= BIAS;
            first_r <= first_nxt;
            second_r <= second_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops.
    assign tbl_req_o = req_r;
    assign tbl_addr_o = taddr_r;
    assign tbl_aux_o = aux_r;
    assign busy_o = req_r;
    assign done_o = done_r;
    assign invalid_digit_flag_o = inv_r;
    assign wrap_o = wrap_r;
    assign zone_o = zone_r;
    // High byte is the high-order bias, low byte the low-order bias.
    assign bias_o = bias_r;
    assign first_operand_addr_pair_o = first_r;
    assign second_operand_addr_pair_o = second_r;

    // ==========================================================
    // Checks
    // The bias register loads one edge after release, so the first edge is skipped.
    a_bias_value: assert property (@(posedge clock_i) disable iff (!rst_n)
        (rst_q2_r && $past(rst_q2_r)) |-> bias_o == 16'(HOST_SIZE - EMU_SIZE))
        else $error("bias not host size minus emulated size");

    a_hund_addr: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_HUND_LO || st_r == LAT_HUND_HI) |-> tbl_addr_o[7:4] == 4'h2)
        else $error("hundreds table address page wrong");

    a_aux_same_addr: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_HUND_LO && tbl_ack_i) |=> tbl_aux_o && $stable(tbl_addr_o))
        else $error("high byte not read from auxiliary area at same address");

    a_tens_addr: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_HUND_HI && tbl_ack_i) |=> tbl_addr_o == {4'h1, tens_r} && !tbl_aux_o)
        else $error("tens table address wrong");

    a_stage_order: assert property (@(posedge clock_i) disable iff (!rst_n)
        ((st_r == LAT_HUND_LO && tbl_ack_i) |=> st_r == LAT_HUND_HI)
        and ((st_r == LAT_HUND_HI && tbl_ack_i) |=> st_r == LAT_TENS))
        else $error("stages out of order");

    a_hund_only: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_HUND_LO && tbl_ack_i) |=> acc_r == {8'h00, unswap($past(tbl_data_i))})
        else $error("hundreds stage mixed in other digits");

    a_result_pair: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_UNITS && tbl_ack_i) |=> done_o
        && second_r == 16'($past(acc_r) + {8'h00, $past(tbl_data_i)}))
        else $error("second pair not loaded with full sum");

    a_first_copy: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_UNITS && tbl_ack_i && afield_r) |=> first_r == second_r)
        else $error("first pair not copied");

    a_invalid_seen: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_TENS && tbl_ack_i && tbl_data_i[4]) |=> invalid_digit_flag_o
        throughout (st_r != LAT_IDLE)[*1] ##0 1'b1)
        else $error("invalid readout not flagged");

    a_req_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
        (tbl_req_o && !tbl_ack_i) |=> tbl_req_o && $stable(tbl_addr_o))
        else $error("request dropped before ack");

    // The units lookup follows the tens lookup on the local page zero.
    a_units_addr: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == LAT_TENS && tbl_ack_i) |=> tbl_addr_o == {4'h0, units_r} && !tbl_aux_o)
        else $error("units table address wrong");

    // A lingering done would let a caller take stale pairs twice.
    a_done_pulse: assert property (@(posedge clock_i) disable iff (!rst_n)
        done_o |=> !done_o)
        else $error("done held longer than one cycle");

    // A decrement outside the final ack cycle must step the second pair by one.
    a_dec_counter: assert property (@(posedge clock_i) disable iff (!rst_n)
        (dec_second_i && !(st_r == LAT_UNITS && tbl_ack_i))
        |=> second_r == 16'($past(second_r) - 16'h0001))
        else $error("second pair did not count down");

endmodule

`default_nettype wire

// ---- include/lat_defs.svh ----
`ifndef LAT_DEFS_SVH
`define LAT_DEFS_SVH
// Contract
// - Bias equals host storage size minus emulated size, added to every address.
// - Bias splits into a low-order byte bias and a high-order byte bias.
// - Hundreds table address is hundreds digit in low nibble, high nibble 2.
// - Hundreds address reads low byte locally, high byte from the auxiliary area.
// - Tens table address has high nibble 1, low nibble tens digit; value added.
// - Hundreds first, then tens added, then units added, in that order.
// - Hundreds lookup treats tens and units as zero; tens lookup treats units zero.
// - Result goes to second pair; first-operand results also copy to first pair.
// - Hundreds and units zone bits are tested apart, never through the tables.
// - A readout with bit 3 set marks the address invalid; the code does not test the hundreds high-byte readout from the auxiliary area.
// - Upward wrap is caught by ordinary host storage wrap checking.
// - The two address pairs serve as the operand address counters.

// ==========================================================
// Table addressing
`define LAT_HUND_PAGE 4'h2
`define LAT_TENS_PAGE 4'h1
`define LAT_UNITS_PAGE 4'h0
// Bit 3 counted from the left of the byte, i.e. weight 0x10.
`define LAT_INVALID_BIT 4
`define LAT_TRAP_CHAR 8'h8f
// ==========================================================
// Sizes
`define LAT_HOST_SIZE 16384
`define LAT_EMU_SIZE 4000
`endif

// ---- include/lat_pkg.sv ----
package lat_pkg;
    // ==========================================================
    // Conversion sequencer states.
    typedef enum logic [2:0] {
        LAT_IDLE,
        LAT_HUND_LO,
        LAT_HUND_HI,
        LAT_TENS,
        LAT_UNITS
    } lat_state_t;
endpackage

// ---- dv/lat_table_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lat_table_model #(
    parameter int BIAS = 12384
) (
    input wire logic clock_i, // System clock.
    input wire logic rst_n_i, // Active-low reset.
    input wire logic [1:0] wait_i, // Idle cycles before each answer.
    input wire logic req_i, // Table read request.
    input wire logic [7:0] addr_i, // Table address.
    input wire logic aux_i, // High selects the auxiliary area.
    output logic ack_o, // Readout valid this cycle.
    output logic [7:0] data_o // Readout.
);
    // ==========================================================
    // Table contents
    logic [7:0] local_mem [256];
    logic [7:0] aux_mem [256];
    logic [1:0] wait_r;
    logic [7:0] idle_r;
    int v;
    // Every slot that no valid digit reaches carries the flag bit.
    initial begin
        for (int i = 0; i < 256; i++) begin
            local_mem[i] = 8'h10;
            aux_mem[i] = 8'h10;
        end
        for (int d = 0; d < 10; d++) begin
            v = BIAS + d * 100;
            // Hundreds low bytes are kept crossed; high bytes of the biased value are stored as read.
            local_mem[8'h20 + d] = {v[3:0], v[7:4]};
            aux_mem[8'h20 + d] = v[15:8];
            v = d * 10;
            local_mem[8'h10 + d] = {v[3:0], v[7:4]};
            local_mem[d] = v[7:0] / 8'h0a;
        end
    end
    // ==========================================================
    // Answer timing
    // A released data bus toggles so a late sample can look right only on a tens 9 lookup, whose readout 0xa5 is also an idle value.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 2'h0;
            idle_r <= 8'h5a;
        end else begin
            idle_r <= ~idle_r;
            wait_r <= (!req_i || ack_o) ? 2'h0 : wait_r + 2'h1;
        end
    end
    assign ack_o = req_i && (wait_r >= wait_i);
    assign data_o = !ack_o ? idle_r : (aux_i ? aux_mem[addr_i] : local_mem[addr_i]);
endmodule
`default_nettype wire

// ---- dv/test_legacy_address_translator.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("MISMATCH %0t %s", $time, msg); \
    end \
end
module test_legacy_address_translator;
    localparam int BIAS = 16384 - 4000;
    logic clock_i, rst_n_i, start_i, a_field_i, dec_first_i, dec_second_i;
    logic [7:0] hund_i, tens_i, units_i, tbl_addr_o, tbl_data_i;
    logic tbl_req_o, tbl_aux_o, tbl_ack_i, busy_o, done_o, invalid_digit_flag_o, wrap_o;
    logic [3:0] zone_o;
    logic [15:0] bias_o, first_operand_addr_pair_o, second_operand_addr_pair_o;
    logic [1:0] wait_sel;
    logic [8:0] trace [$];
    int bad_count, samples_checked, cycles;
    lat_translator u_lat_translator (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i),
        .hund_i(hund_i), .tens_i(tens_i), .units_i(units_i), .a_field_i(a_field_i),
        .dec_first_i(dec_first_i), .dec_second_i(dec_second_i), .tbl_req_o(tbl_req_o),
        .tbl_addr_o(tbl_addr_o), .tbl_aux_o(tbl_aux_o), .tbl_ack_i(tbl_ack_i),
        .tbl_data_i(tbl_data_i), .busy_o(busy_o), .done_o(done_o),
        .invalid_digit_flag_o(invalid_digit_flag_o), .wrap_o(wrap_o), .zone_o(zone_o),
        .bias_o(bias_o), .first_operand_addr_pair_o(first_operand_addr_pair_o),
        .second_operand_addr_pair_o(second_operand_addr_pair_o));
    lat_table_model #(.BIAS(BIAS)) u_lat_table_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .wait_i(wait_sel), .req_i(tbl_req_o), .addr_i(tbl_addr_o), .aux_i(tbl_aux_o),
        .ack_o(tbl_ack_i), .data_o(tbl_data_i));
    // ==========================================================
    // Clock, read trace and hang guard
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // Every accepted table read is logged as {aux, address}.
    always @(posedge clock_i) begin
        if (tbl_req_o === 1'b1 && tbl_ack_i === 1'b1) trace.push_back({tbl_aux_o, tbl_addr_o});
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Shared conversion driver
    // Launches one conversion and returns at the falling edge where done is high.
    task automatic convert(input logic [7:0] hc, tc, uc, input logic af, input logic [1:0] w);
        int n;
        trace.delete();
        wait_sel = w;
        @(negedge clock_i);
        {hund_i, tens_i, units_i, a_field_i, start_i} = {hc, tc, uc, af, 1'b1};
        @(negedge clock_i);
        start_i = 1'b0;
        `CHK(busy_o, 1'b1, "not busy after start")
        for (n = 0; n < 40 && done_o !== 1'b1; n++) @(negedge clock_i);
        `CHK(done_o, 1'b1, "conversion never completed")
        `CHK(busy_o, 1'b0, "busy after done")
    endtask
    function automatic logic [15:0] expect_addr(input logic [7:0] hc, tc, uc);
        return 16'(BIAS + hc[3:0] * 100 + tc[3:0] * 10 + uc[3:0]);
    endfunction
    // ==========================================================
    // Scenarios
    task automatic reset_values();
        `CHK(bias_o, 16'h3060, "bias value")
        `CHK(done_o, 1'b0, "done after reset")
    endtask
    // First-operand conversion with prompt memory; read order and addresses checked.
    task automatic worked_example();
        logic [8:0] exp_reads [4] = '{9'h021, 9'h121, 9'h012, 9'h002};
        convert(8'hf1, 8'hf2, 8'hf2, 1'b1, 2'h0);
        `CHK(second_operand_addr_pair_o, 16'h30da, "second pair")
        `CHK(first_operand_addr_pair_o, 16'h30da, "first pair copy")
        `CHK(trace.size(), 4, "read count")
        for (int i = 0; i < 4; i++) `CHK(trace[i], exp_reads[i], "read order")
        `CHK(invalid_digit_flag_o, 1'b0, "valid address flagged")
    endtask
    // Low byte overflows into the high byte; slow memory; second field only.
    task automatic carry_slow();
        convert(8'hf1, 8'hf9, 8'hf9, 1'b0, 2'h2);
        `CHK(second_operand_addr_pair_o, expect_addr(8'h1, 8'h9, 8'h9), "carry sum")
        `CHK(first_operand_addr_pair_o, 16'h30da, "first pair disturbed")
    endtask
    // Highest three-digit address stays inside host storage without wrapping.
    task automatic top_and_zones();
        convert(8'he9, 8'hf9, 8'hd9, 1'b1, 2'h1);
        `CHK(second_operand_addr_pair_o, expect_addr(8'h9, 8'h9, 8'h9), "top address")
        `CHK(wrap_o, 1'b0, "false wrap")
        `CHK(zone_o, 4'h9, "zone bits")
    endtask
    task automatic bad_digit();
        convert(8'hf2, 8'hfa, 8'hf0, 1'b0, 2'h0);
        `CHK(invalid_digit_flag_o, 1'b1, "bad tens digit missed")
        convert(8'hf3, 8'hf0, 8'hfc, 1'b0, 2'h1);
        `CHK(invalid_digit_flag_o, 1'b1, "bad units digit missed")
        convert(8'hfb, 8'hf0, 8'hf0, 1'b0, 2'h0);
        `CHK(invalid_digit_flag_o, 1'b1, "bad hundreds digit missed")
        convert(8'hf5, 8'hf0, 8'hf1, 1'b0, 2'h0);
        `CHK(invalid_digit_flag_o, 1'b0, "flag not cleared")
        `CHK(second_operand_addr_pair_o, expect_addr(8'h5, 8'h0, 8'h1), "hundreds five")
    endtask
    // Both pairs step down as operand address counters.
    task automatic count_down();
        logic [15:0] f, s;
        convert(8'hf0, 8'hf0, 8'hf0, 1'b1, 2'h0);
        `CHK(second_operand_addr_pair_o, 16'(BIAS), "address zero")
        f = first_operand_addr_pair_o;
        s = second_operand_addr_pair_o;
        {dec_first_i, dec_second_i} = 2'b11;
        @(negedge clock_i);
        {dec_first_i, dec_second_i} = 2'b00;
        `CHK(first_operand_addr_pair_o, f - 16'h1, "first counter")
        `CHK(second_operand_addr_pair_o, s - 16'h1, "second counter")
        `CHK(first_operand_addr_pair_o, 16'(BIAS - 1), "zero minus one not trap slot")
    endtask
    // ==========================================================
    // Main sequence: reset held five cycles, first start four falling edges later.
    initial begin
        {rst_n_i, start_i, a_field_i, dec_first_i, dec_second_i} = 5'h0;
        {hund_i, tens_i, units_i, wait_sel} = 26'h0;
        repeat (5) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        reset_values();
        worked_example();
        carry_slow();
        top_and_zones();
        bad_digit();
        count_down();
        tally_and_finish();
    end
endmodule
`default_nettype wire
